/* File: hw/lmov_defs.svh */
/*
 * Constants for the literal and indirect move execution block:
 * opcode match patterns, fixed file addresses and reset values.
 * Assumes a 14-bit program word and a 16-bit data address space.
 */
`ifndef LMOV_DEFS_SVH
`define LMOV_DEFS_SVH

// ============================================================
// Opcode match fields (only opcode bits are ever compared)
// ============================================================
`define LMOV_LIT_ACC_OPC 6'h30
`define LMOV_LIT_PCL_OPC 7'h63
`define LMOV_ST_FILE_OPC 7'h01
`define LMOV_ST_IND_OPC 11'h003
`define LMOV_ST_REL_OPC 7'h7F

// ============================================================
// Fixed file addresses of the two indirect access ports
// ============================================================
`define LMOV_IND_PORT0 7'h00
`define LMOV_IND_PORT1 7'h01

// ============================================================
// Reset values
// ============================================================
`define LMOV_ACC_RST 8'h00
`define LMOV_PCL_RST 7'h00
`define LMOV_FLAGS_RST 3'h0
`define LMOV_PTR_RST 16'h0000

`endif

/* File: hw/lmov_pkg.sv */
/*
 * Types shared by the move execution block and its pointer unit.
 * Assumes nothing beyond a SystemVerilog tool.
 */
package lmov_pkg;
    // Pointer update mode, encoded as in the program word
    typedef enum logic [1:0] {
        LMOV_PRE_INC = 2'b00,
        LMOV_PRE_DEC = 2'b01,
        LMOV_POST_INC = 2'b10,
        LMOV_POST_DEC = 2'b11
    } lmov_mode_t;

    // Decoded operation
    typedef enum logic [2:0] {
        LMOV_OP_NONE = 3'b000,
        LMOV_OP_LIT_ACC = 3'b001,
        LMOV_OP_LIT_PCL = 3'b010,
        LMOV_OP_ST_FILE = 3'b011,
        LMOV_OP_ST_IND = 3'b100,
        LMOV_OP_ST_REL = 3'b101
    } lmov_op_t;
endpackage

/* File: hw/lmov_ptr_if.sv */
/*
 * Carrier between the move core and its pointer unit.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ns
interface lmov_ptr_if;
    import lmov_pkg::*;
    logic req; // Store uses a pointer this cycle
    logic upd; // Apply the mode's pointer update
    logic sel; // Pointer index
    lmov_mode_t mode; // Pre/post inc/dec
    logic rel; // Signed offset form, pointer kept
    logic [5:0] offset; // Signed offset
    logic [15:0] eff_addr; // Effective address
    logic load; // Outside write to a pointer
    logic load_sel; // Which pointer is written
    logic [15:0] load_val; // Value written
    logic [15:0] ptr0; // Pointer 0 contents
    logic [15:0] ptr1; // Pointer 1 contents

    modport core (output req, upd, sel, mode, rel, offset, load, load_sel,
        load_val, input eff_addr, ptr0, ptr1);
    modport unit (input req, upd, sel, mode, rel, offset, load, load_sel,
        load_val, output eff_addr, ptr0, ptr1);
endinterface

/* File: hw/lmov_ptr_unit.sv */
/*
 * Two 16-bit indirect pointers with effective address generation.
 * Assumes the core raises req for one cycle per indirect store.
 */
`timescale 1ns/1ns
`include "lmov_defs.svh"
module lmov_ptr_unit (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Core side
    lmov_ptr_if.unit pif
);
    import lmov_pkg::*;

    logic [15:0] ptr_q [2]; // Pointer storage
    logic [15:0] cur; // Selected pointer
    logic [15:0] stepped; // Pointer after its step
    logic [15:0] offs_ext; // Sign-extended offset

    // ============================================================
    // Address arithmetic
    // ============================================================
    // Plain 16-bit sum: carry out is dropped so it wraps
    function automatic logic [15:0] wrap_add(input logic [15:0] a,
            input logic [15:0] b);
        wrap_add = a + b;
    endfunction

    assign cur = ptr_q[pif.sel];
    assign offs_ext = {{10{pif.offset[5]}}, pif.offset};
    // Odd mode codes decrement
    assign stepped = wrap_add(cur, pif.mode[0] ? 16'hFFFF : 16'h0001);

    // Relative: pointer + k; pre: stepped; post: pointer as is
    always_comb begin
        if (pif.rel) begin
            pif.eff_addr = wrap_add(cur, offs_ext);
        end else if (!pif.mode[1]) begin
            pif.eff_addr = stepped;
        end else begin
            pif.eff_addr = cur;
        end
    end

    // ============================================================
    // Pointer update; the store's own update beats an outside load
    // ============================================================
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            ptr_q[0] <= `LMOV_PTR_RST;
            ptr_q[1] <= `LMOV_PTR_RST;
        end else if (pif.req && pif.upd && !pif.rel) begin
            ptr_q[pif.sel] <= stepped;
        end else if (pif.load) begin
            ptr_q[pif.load_sel] <= pif.load_val;
        end
    end

    assign pif.ptr0 = ptr_q[0];
    assign pif.ptr1 = ptr_q[1];

    // ============================================================
    // Checks
    // ============================================================
    // Pre-increment: address is pointer + 1 and the pointer keeps it
    a_pre_inc_addr: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        pif.req && pif.upd && !pif.rel && pif.mode == LMOV_PRE_INC |->
        pif.eff_addr == cur + 16'h0001 ##1
        (($past(pif.sel) ? pif.ptr1 : pif.ptr0) == $past(pif.eff_addr)))
        else $error("pre-increment address wrong");
    a_post_dec_upd: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        pif.req && pif.upd && !pif.rel &&
        pif.mode == LMOV_POST_DEC && !pif.sel |-> pif.eff_addr == cur ##1
        pif.ptr0 == $past(cur) - 16'h0001)
        else $error("post-decrement update wrong");
    a_rel_keeps_ptr: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        pif.req && pif.rel && !pif.load |=>
        $stable(pif.ptr0) && $stable(pif.ptr1))
        else $error("relative store moved a pointer");
    a_wrap_top: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        pif.req && pif.upd && !pif.rel && !pif.sel &&
        pif.mode == LMOV_POST_INC && cur == 16'hFFFF |=>
        pif.ptr0 == 16'h0000)
        else $error("pointer did not wrap");
endmodule // lmov_ptr_unit

/* File: hw/lmov_core.sv */
/*
 * Execution of five move instructions: literal to program counter
 * high latch, literal to accumulator, accumulator to file register,
 * and accumulator stored through one of two pointers, stepped or at a signed offset.
 * Assumes a decoded-ready 14-bit word each valid cycle from fetch,
 * and a data memory write port that takes one write per cycle.
 */
// Functional notes
// - Literal loads 7-bit program counter high latch
// - Literal loads accumulator, one cycle, flags kept
// - Decode compares opcode bits only
// - Accumulator written to 7-bit file address
// - Mode 00/01/10/11 pre/post increment/decrement
// - Pre modes use stepped pointer; post after
// - Offset form adds signed k, pointer kept
// - Indirect ports redirect to pointer address
// - Pointer arithmetic wraps modulo 16 bits
// - Pointer steps never change status flags
`timescale 1ns/1ns
`include "lmov_defs.svh"
module lmov_core (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Instruction from fetch
    input wire logic instr_valid_i,
    input wire logic [13:0] instr_i,
    // Pointer load from other instructions
    input wire logic ptr_load_i,
    input wire logic ptr_load_sel_i,
    input wire logic [15:0] ptr_load_val_i,
    // Status flags written by the arithmetic unit
    input wire logic flags_load_i,
    input wire logic [2:0] flags_val_i,
    // Architectural state
    output logic [7:0] acc_o,
    output logic [6:0] pc_latch_o,
    output logic [2:0] flags_o,
    output logic [15:0] ptr0_o,
    output logic [15:0] ptr1_o,
    // Data memory write port
    output logic mem_we_o,
    output logic [15:0] mem_addr_o,
    output logic [7:0] mem_wdata_o,
    // Decoded operation, for debug
    output lmov_pkg::lmov_op_t op_o
);
    import lmov_pkg::*;

    // ============================================================
    // Declarations
    // ============================================================
    logic [7:0] acc_q; // Working register
    logic [6:0] pcl_q; // Program counter high latch
    logic [2:0] flags_q; // Zero, digit carry, carry
    logic mem_we_q; // Write strobe
    logic [15:0] mem_addr_q; // Write address
    logic [7:0] mem_wdata_q; // Write data
    lmov_op_t op_q; // Last decoded operation
    lmov_op_t op_d; // Decoded operation this cycle
    logic ind_port; // File store hits an indirect port
    logic [6:0] file_addr; // File operand

    lmov_ptr_if pif ();

    // ============================================================
    // Decode
    // ============================================================
    // Only the fixed opcode bits are compared; operand fields never
    // steer the choice, so assembler zero padding is irrelevant
    always_comb begin
        op_d = LMOV_OP_NONE;
        if (instr_valid_i) begin
            if (instr_i[13:8] == `LMOV_LIT_ACC_OPC) begin
                op_d = LMOV_OP_LIT_ACC;
            end else if (instr_i[13:7] == `LMOV_LIT_PCL_OPC) begin
                op_d = LMOV_OP_LIT_PCL;
            end else if (instr_i[13:7] == `LMOV_ST_FILE_OPC) begin
                op_d = LMOV_OP_ST_FILE;
            end else if (instr_i[13:3] == `LMOV_ST_IND_OPC) begin
                op_d = LMOV_OP_ST_IND;
            end else if (instr_i[13:7] == `LMOV_ST_REL_OPC) begin
                op_d = LMOV_OP_ST_REL;
            end else begin
                op_d = LMOV_OP_NONE; // Not ours
            end
        end
    end

    assign file_addr = instr_i[6:0];
    // Ports hold no storage; a file store there goes through a pointer
    assign ind_port = (file_addr == `LMOV_IND_PORT0) ||
        (file_addr == `LMOV_IND_PORT1);

    // ============================================================
    // Pointer unit requests
    // ============================================================
    // Indirect-port file stores use the offset form with k = 0, which
    // gives the plain pointer address and leaves the pointer alone
    always_comb begin
        pif.req = 1'b0;
        pif.upd = 1'b0;
        pif.rel = 1'b0;
        pif.sel = 1'b0;
        pif.mode = LMOV_PRE_INC;
        pif.offset = 6'h00;
        case (op_d)
            LMOV_OP_ST_IND: begin
                pif.req = 1'b1;
                pif.upd = 1'b1;
                pif.sel = instr_i[2];
                pif.mode = lmov_mode_t'(instr_i[1:0]);
            end
            LMOV_OP_ST_REL: begin
                pif.req = 1'b1;
                pif.rel = 1'b1;
                pif.sel = instr_i[6];
                pif.offset = instr_i[5:0];
            end
            LMOV_OP_ST_FILE: begin
                pif.req = ind_port;
                pif.rel = 1'b1;
                pif.sel = file_addr[0];
            end
            default: begin
                pif.req = 1'b0;
            end
        endcase
    end

    assign pif.load = ptr_load_i;
    assign pif.load_sel = ptr_load_sel_i;
    assign pif.load_val = ptr_load_val_i;

    lmov_ptr_unit u_ptr (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .pif(pif)
    );

    // ============================================================
    // Working register
    // ============================================================
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            acc_q <= `LMOV_ACC_RST;
        end else if (op_d == LMOV_OP_LIT_ACC) begin
            acc_q <= instr_i[7:0];
        end
    end

    // ============================================================
    // Program counter high latch
    // ============================================================
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            pcl_q <= `LMOV_PCL_RST;
        end else if (op_d == LMOV_OP_LIT_PCL) begin
            pcl_q <= instr_i[6:0];
        end
    end

    // ============================================================
    // Status flags: only the arithmetic unit writes them; none of
    // the moves here, pointer steps included, touch them
    // ============================================================
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            flags_q <= `LMOV_FLAGS_RST;
        end else if (flags_load_i) begin
            flags_q <= flags_val_i;
        end
    end

    // ============================================================
    // Data memory write: registered, one cycle after the word
    // ============================================================
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            mem_we_q <= 1'b0;
            mem_addr_q <= 16'h0000;
            mem_wdata_q <= 8'h00;
        end else begin
            mem_we_q <= 1'b0;
            if (pif.req) begin
                mem_we_q <= 1'b1;
                mem_addr_q <= pif.eff_addr;
                mem_wdata_q <= acc_q;
            end else if (op_d == LMOV_OP_ST_FILE) begin
                mem_we_q <= 1'b1;
                mem_addr_q <= {9'h000, file_addr};
                mem_wdata_q <= acc_q;
            end
        end
    end

    // ============================================================
    // Debug record of the decode
    // ============================================================
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            op_q <= LMOV_OP_NONE;
        end else begin
            op_q <= op_d;
        end
    end

    assign acc_o = acc_q;
    assign pc_latch_o = pcl_q;
    assign flags_o = flags_q;
    assign ptr0_o = pif.ptr0;
    assign ptr1_o = pif.ptr1;
    assign mem_we_o = mem_we_q;
    assign mem_addr_o = mem_addr_q;
    assign mem_wdata_o = mem_wdata_q;
    assign op_o = op_q;

    // ============================================================
    // Checks
    // ============================================================
    a_pcl_literal_load: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        op_d == LMOV_OP_LIT_PCL |=>
        pc_latch_o == $past(instr_i[6:0]) && !mem_we_o)
        else $error("latch literal not loaded");
    a_acc_literal_load: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        instr_valid_i && instr_i[13:8] == 6'h30 |=>
        acc_o == $past(instr_i[7:0]))
        else $error("accumulator literal not loaded");
    a_opcode_bits_only: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        instr_valid_i && instr_i[13:8] == 6'h30 |->
        op_d == LMOV_OP_LIT_ACC)
        else $error("literal decode depends on operand");
    a_file_store_write: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        op_d == LMOV_OP_ST_FILE && !ind_port |=>
        mem_we_o && mem_addr_o == {9'h000, $past(file_addr)} &&
        mem_wdata_o == $past(acc_o))
        else $error("file store wrong");
    a_port_redirect: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        op_d == LMOV_OP_ST_FILE && file_addr == 7'h01 |=>
        mem_we_o && mem_addr_o == $past(ptr1_o) && $stable(ptr1_o))
        else $error("indirect port not redirected");
    a_flags_unchanged: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        op_d != LMOV_OP_NONE && !flags_load_i |=>
        $stable(flags_o))
        else $error("move changed status flags");
    a_ind_sel_addr: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        op_d == LMOV_OP_ST_IND && instr_i[1] && instr_i[2] |=>
        mem_we_o && mem_addr_o == $past(ptr1_o))
        else $error("post mode used wrong pointer");
    a_rel_offset_addr: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        op_d == LMOV_OP_ST_REL && !instr_i[6] |=>
        mem_addr_o == $past(ptr0_o) +
        {{10{$past(instr_i[5])}}, $past(instr_i[5:0])})
        else $error("relative address wrong");
endmodule // lmov_core

/* File: sim/test_lmov_core.sv */
/*
 * Self-checking bench for the move execution core: literal loads,
 * file stores, indirect stores in every mode and the offset form.
 * Assumes the hw/ package, interface and modules are compiled first.
 */
`timescale 1ns/1ns
module test_lmov_core;
    import lmov_pkg::*;
    // ==========================================================
    // Design inputs, all given a value at time zero
    // ==========================================================
    logic sys_clk_i = 1'b0; // 50 MHz core clock
    logic reset_i = 1'b1; // Synchronous reset, held at start
    logic instr_valid_i = 1'b0; // Word present
    logic [13:0] instr_i = 14'h0000; // Program word
    logic ptr_load_i = 1'b0; // Outside pointer write
    logic ptr_load_sel_i = 1'b0; // Which pointer
    logic [15:0] ptr_load_val_i = 16'h0000; // Pointer value
    logic flags_load_i = 1'b0; // Outside flag write
    logic [2:0] flags_val_i = 3'h0; // Flag value
    // Design outputs
    logic [7:0] acc_o;
    logic [6:0] pc_latch_o;
    logic [2:0] flags_o;
    logic [15:0] ptr0_o;
    logic [15:0] ptr1_o;
    logic mem_we_o;
    logic [15:0] mem_addr_o;
    logic [7:0] mem_wdata_o;
    lmov_op_t op_o;
    // ==========================================================
    // Expected state, kept by the bench alone
    // ==========================================================
    logic [7:0] m_acc = 8'h00;
    logic [6:0] m_pcl = 7'h00;
    logic [2:0] m_flg = 3'h0;
    logic [15:0] m_ptr [2] = '{16'h0000, 16'h0000};
    logic m_we;
    logic [15:0] m_addr;
    logic [7:0] m_wdata;
    lmov_op_t m_op;
    int n_mismatch = 0;
    int checks_done = 0;
    int seed;

    // Clock: inverted every half period of 10 ns
    always #10 sys_clk_i = ~sys_clk_i;

    lmov_core dut_u (
        .sys_clk_i, .reset_i, .instr_valid_i, .instr_i, .ptr_load_i,
        .ptr_load_sel_i, .ptr_load_val_i, .flags_load_i, .flags_val_i,
        .acc_o, .pc_latch_o, .flags_o, .ptr0_o, .ptr1_o, .mem_we_o,
        .mem_addr_o, .mem_wdata_o, .op_o
    );

    // ==========================================================
    // Encoders for the five instruction forms
    // ==========================================================
    function automatic logic [13:0] la(input logic [7:0] k);
        return {6'h30, k};
    endfunction
    function automatic logic [13:0] lp(input logic [6:0] k);
        return {7'h63, k};
    endfunction
    function automatic logic [13:0] sf(input logic [6:0] f);
        return {7'h01, f};
    endfunction
    function automatic logic [13:0] si(input logic n, input logic [1:0] m);
        return {11'h003, n, m};
    endfunction
    function automatic logic [13:0] sr(input logic n, input logic [5:0] k);
        return {7'h7F, n, k};
    endfunction
    // Expected pointer after one step; odd mode codes count down
    function automatic logic [15:0] nxt_ptr(input logic [15:0] p,
            input logic dn);
        return dn ? p - 16'h0001 : p + 16'h0001;
    endfunction

    // ==========================================================
    // Comparison, verdict and the one driving task
    // ==========================================================
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("Counts: %0d checks, %0d mismatches", checks_done,
            n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Drive one cycle at the falling edge, predict, check after rise
    task automatic step(input logic v, input logic [13:0] w,
            input logic pl, input logic ps, input logic [15:0] pv,
            input logic fl, input logic [2:0] fv);
        logic [15:0] p;
        logic upd;
        @(negedge sys_clk_i);
        instr_valid_i = v;
        instr_i = w;
        ptr_load_i = pl;
        ptr_load_sel_i = ps;
        ptr_load_val_i = pv;
        flags_load_i = fl;
        flags_val_i = fv;
        m_we = 1'b0;
        m_op = LMOV_OP_NONE;
        m_wdata = m_acc;
        upd = 1'b0;
        // Stores read the pointers as they were before the edge
        if (v) casez (w)
            14'b11_0000_????????: begin
                m_acc = w[7:0];
                m_op = LMOV_OP_LIT_ACC;
            end
            14'b11_0001_1???????: begin
                m_pcl = w[6:0];
                m_op = LMOV_OP_LIT_PCL;
            end
            14'b00_0000_1???????: begin
                m_we = 1'b1;
                m_op = LMOV_OP_ST_FILE;
                // Ports 00/01 redirect through the pointers
                m_addr = (w[6:1] == 6'h00) ? m_ptr[w[0]] : {9'h000, w[6:0]};
            end
            14'b00_0000_0001_1???: begin
                m_we = 1'b1;
                m_op = LMOV_OP_ST_IND;
                upd = 1'b1;
                p = m_ptr[w[2]];
                m_addr = w[1] ? p : nxt_ptr(p, w[0]);
                m_ptr[w[2]] = nxt_ptr(p, w[0]);
            end
            14'b11_1111_1???????: begin
                m_we = 1'b1;
                m_op = LMOV_OP_ST_REL;
                m_addr = m_ptr[w[6]] + {{10{w[5]}}, w[5:0]};
            end
            default: begin
                m_op = LMOV_OP_NONE;
            end
        endcase
        // An updating store wins over a load in the same cycle
        if (pl && !upd) begin
            m_ptr[ps] = pv;
        end
        if (fl) begin
            m_flg = fv;
        end
        @(posedge sys_clk_i);
        #1;
        check(acc_o, m_acc);
        check(pc_latch_o, m_pcl);
        check(flags_o, m_flg);
        check(ptr0_o, m_ptr[0]);
        check(ptr1_o, m_ptr[1]);
        check(mem_we_o, m_we);
        check(op_o, m_op);
        if (m_we) begin
            check(mem_addr_o, m_addr);
            check(mem_wdata_o, m_wdata);
        end
    endtask

    task automatic ins(input logic [13:0] w);
        step(1'b1, w, 1'b0, 1'b0, 16'h0000, 1'b0, 3'h0);
    endtask
    task automatic ld(input logic s, input logic [15:0] v);
        step(1'b0, 14'h0000, 1'b1, s, v, 1'b0, 3'h0);
    endtask

    // ==========================================================
    // Watchdog: a hang counts as a mismatch
    // ==========================================================
    initial begin
        #400000;
        n_mismatch++;
        test_done();
    end

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        logic [13:0] w;
        int r;
        seed = $urandom(67613);
        repeat (12) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        reset_i = 1'b0;
        check(acc_o, 16'h0000);
        check(mem_we_o, 16'h0000);
        check(ptr0_o, 16'h0000);
        $display("test reset done");
        // Boundary literals, back to back
        ins(la(8'h00));
        ins(la(8'hFF));
        ins(lp(7'h7F));
        ins(lp(7'h00));
        $display("test literal done");
        // Flags set from outside must survive an indirect store and a latch literal load
        step(1'b1, la(8'h5A), 1'b0, 1'b0, 16'h0000, 1'b1, 3'h5);
        ins(si(1'b0, 2'b00));
        ins(lp(7'h2A));
        $display("test flags done");
        // File stores, including the two redirecting ports
        ld(1'b0, 16'h1234);
        ld(1'b1, 16'h8000);
        ins(la(8'h4F));
        for (int f = 0; f < 4; f++) begin
            ins(sf(f[6:0]));
        end
        ins(sf(7'h7F));
        ins(sf(7'h2A));
        $display("test file store done");
        // All four modes on both pointers, each from both wrap edges
        for (int m = 0; m < 4; m++) begin
            for (int n = 0; n < 4; n++) begin
                ld(n[0], n[1] ? 16'hFFFF : 16'h0000);
                ins(la(8'($urandom)));
                ins(si(n[0], m[1:0]));
                ins(si(n[0], m[1:0]));
            end
        end
        $display("test indirect done");
        // Offset form at the offset limits, pointer kept
        ld(1'b0, 16'hFFF0);
        ld(1'b1, 16'h0010);
        for (int n = 0; n < 2; n++) begin
            ins(sr(n[0], 6'h20));
            ins(sr(n[0], 6'h1F));
            ins(sr(n[0], 6'h00));
            ins(sr(n[0], 6'h3F));
        end
        $display("test offset done");
        // Load against an updating store, then ignored words
        ld(1'b0, 16'h0100);
        step(1'b1, si(1'b0, 2'b10), 1'b1, 1'b0, 16'h1234, 1'b0, 3'h0);
        ins(14'h0000);
        step(1'b0, la(8'hC3), 1'b0, 1'b0, 16'h0000, 1'b0, 3'h0);
        $display("test conflict done");
        // Random mix; pointer loads only beside non-pointer ops
        for (int i = 0; i < 400; i++) begin
            r = $urandom_range(0, 5);
            w = 14'($urandom);
            case (r)
                0: w = la(w[7:0]);
                1: w = lp(w[6:0]);
                2: w = sf(w[6:0]);
                3: w = si(w[2], w[1:0]);
                4: w = sr(w[6], w[5:0]);
                default: w = 14'h0000;
            endcase
            step(1'($urandom_range(0, 7) != 0), w,
                1'(r < 2 && $urandom_range(0, 1)), 1'($urandom),
                16'($urandom), 1'($urandom), 3'($urandom));
        end
        $display("test random done");
        test_done();
    end
endmodule // test_lmov_core
